// *** rtl/cmdc_defs.vh ***
// cmdc_defs.vh: register offsets, field positions, reset values for the mode block
// assumes: included by bare name from the rtl files of this block
`ifndef CMDC_DEFS_VH
`define CMDC_DEFS_VH

// byte addresses on the avalon word bus
`define CMDC_ADDR_W            8
`define CMDC_OFF_CORE_CTRL     8'h18
`define CMDC_OFF_DELAY_COMP    8'h48
`define CMDC_OFF_TX_PENDING    8'hcc
`define CMDC_OFF_CANCEL_DONE   8'hd8
`define CMDC_OFF_CANCEL_IRQ_EN 8'he4
`define CMDC_OFF_STATUS        8'hf0

// core control field positions
`define CMDC_CCR_INIT          0
`define CMDC_CCR_CCE           1
`define CMDC_CCR_ASM           2
`define CMDC_CCR_MON           5
`define CMDC_CCR_LOOP_INT      4
`define CMDC_CCR_LOOP_EXT      7
`define CMDC_CCR_RESET         32'h00000001

// delay compensation register fields
`define CMDC_TDC_FILT_LSB      0
`define CMDC_TDC_W             7
`define CMDC_TDC_RESET         32'h00000000

`define CMDC_CANCEL_IRQ_RESET  32'h00000000
`define CMDC_TX_PENDING_RESET  32'h00000000
`define CMDC_RDATA_UNMAPPED    32'h00000000

`endif

// *** rtl/cmdc_delay_meas.v ***
// cmdc_delay_meas.v: transmitter delay measurement with a minimum filter window
// assumes: receive pin already synchronised, start pulse at the edge it measures from
`timescale 1ns/1ps
`default_nettype none
`include "cmdc_defs.vh"

module cmdc_delay_meas (
   input  wire                   i_ref_clk,   // 20 mhz clock
   input  wire                   i_rst_b,     // async reset, active low
   input  wire                   i_start,     // pulse: measurement begins
   input  wire                   i_rx,        // synchronised receive level
   input  wire [`CMDC_TDC_W-1:0] i_filt_win,  // minimum sample point position
   output reg  [`CMDC_TDC_W-1:0] o_ssp_pos,   // measured sample point position
   output reg                    o_busy,      // measurement running
   output reg                    o_done       // pulse: measurement stopped
);

   reg [`CMDC_TDC_W-1:0] cnt_r;
   wire                  cnt_max = &cnt_r;

   // count from start; early dominant edges below the window are ignored
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_r     <= 7'h00;
         o_ssp_pos <= 7'h00;
         o_busy    <= 1'b0;
         o_done    <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_start) begin
            cnt_r  <= 7'h00;
            o_busy <= 1'b1;
         end else if (o_busy) begin
            // stop at or past the window with the pin low, or at the count limit with the pin still high
            if ((cnt_r >= i_filt_win) && !i_rx) begin
               o_ssp_pos <= cnt_r;
               o_busy    <= 1'b0;
               o_done    <= 1'b1;
            end else if (cnt_max) begin
               // saturate rather than wrap so a stuck bus cannot look short
               o_ssp_pos <= cnt_r;
               o_busy    <= 1'b0;
               o_done    <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 7'h01;
            end
         end
      end
   end

endmodule // cmdc_delay_meas
`default_nettype wire

// *** rtl/cmdc_mode_ctrl.v ***
// cmdc_mode_ctrl.v: operating modes and delay compensation control of the can controller
// assumes: avalon-mm slave on i_ref_clk, protocol engine attached on the proto ports
`timescale 1ns/1ps
`default_nettype none
`include "cmdc_defs.vh"

module cmdc_mode_ctrl (
   input  wire                    i_ref_clk,        // 20 mhz clock
   input  wire                    i_rst_b,          // async reset, active low
   // avalon-mm slave
   input  wire [`CMDC_ADDR_W-1:0] i_avs_address,    // byte address
   input  wire                    i_avs_read,       // read strobe
   input  wire                    i_avs_write,      // write strobe
   input  wire [31:0]             i_avs_writedata,  // write data
   input  wire [3:0]              i_avs_byteenable, // byte lanes
   output reg  [31:0]             o_avs_readdata,   // read data
   output wire                    o_avs_waitrequest,// stall
   // can pins
   input  wire                    i_can_receive_pin,// bus level from transceiver
   output reg                     o_can_tx,         // bus drive, 1 = recessive
   // protocol engine side
   input  wire                    i_proto_tx,       // engine transmit level
   input  wire                    i_proto_tx_start, // engine wants a frame start
   input  wire                    i_proto_tx_dom_req,// bit is ack/error/overload flag
   input  wire                    i_proto_err_inc,  // engine error counter increment
   input  wire                    i_proto_bus_idle, // engine saw bus idle
   input  wire                    i_proto_err_event,// pulse: error or overload seen
   input  wire                    i_proto_meas_start,// pulse: delay measurement start
   input  wire                    i_fetch_underrun, // pulse: tx handler late
   input  wire [31:0]             i_tx_request_set, // pulse per buffer: request added
   input  wire [31:0]             i_tx_request_clr, // pulse per buffer: sent or cancelled
   input  wire [31:0]             i_cancel_done,    // pulse per buffer: cancel finished
   output wire                    o_proto_rx,       // receive level seen by engine
   output wire                    o_proto_tx_allow, // engine may start a frame
   output wire                    o_proto_err_inc_en,// error counters may count
   output wire                    o_proto_hold_sync,// engine waits for bus idle
   output wire [`CMDC_TDC_W-1:0]  o_ssp_pos,        // measured sample point
   output wire                    o_cancel_irq      // cancel-done interrupt level
);

   // avalon transfers answer in one wait cycle: waitrequest drops the cycle after
   reg          ack_r;
   wire         req      = i_avs_read | i_avs_write;
   wire         wr_go    = i_avs_write & ack_r;

   reg  [31:0]  core_ctrl_r;
   reg  [31:0]  core_ctrl_nxt;
   reg  [31:0]  delay_comp_r;
   reg  [31:0]  tx_request_pending_reg_r;
   reg  [31:0]  cancel_done_r;
   reg  [31:0]  tx_buffer_cancel_done_irq_enable_r;
   reg          hold_sync_r;
   reg  [2:0]   rx_sync_r;
   reg          rx_level_r;
   wire         meas_busy;

   wire restricted_op_bit = core_ctrl_r[`CMDC_CCR_ASM];
   wire listen_only_bit   = core_ctrl_r[`CMDC_CCR_MON];
   wire config_change_enable = core_ctrl_r[`CMDC_CCR_CCE];
   wire init_bit          = core_ctrl_r[`CMDC_CCR_INIT];

   // byte-lane merge used by every writable register
   function [31:0] merge_be;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  be;
      integer      k;
      begin
         merge_be = old_v;
         for (k = 0; k < 4; k = k + 1) begin
            if (be[k]) begin
               merge_be[k*8 +: 8] = new_v[k*8 +: 8];
            end
         end
      end
   endfunction

   function sel;
      input [`CMDC_ADDR_W-1:0] a;
      input [`CMDC_ADDR_W-1:0] off;
      begin
         sel = (a == off);
      end
   endfunction

   // one wait state per access; trades a cycle for registered read data
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end
   assign o_avs_waitrequest = req & ~ack_r;

   // receive pin crossing: three stages, change accepted when last two agree
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rx_sync_r  <= 3'b111;
         rx_level_r <= 1'b1;
      end else begin
         rx_sync_r <= {rx_sync_r[1:0], i_can_receive_pin};
         if (rx_sync_r[1] == rx_sync_r[2]) begin
            rx_level_r <= rx_sync_r[2];
         end
      end
   end

   // core control next value: software writes gated, hardware sets restricted mode
   always @* begin
      core_ctrl_nxt = core_ctrl_r;
      if (wr_go && sel(i_avs_address, `CMDC_OFF_CORE_CTRL)) begin
         core_ctrl_nxt = merge_be(core_ctrl_r, i_avs_writedata, i_avs_byteenable);
         // setting only allowed when cce and init are both already one
         if (core_ctrl_nxt[`CMDC_CCR_ASM] && !restricted_op_bit &&
             !(config_change_enable && init_bit)) begin
            core_ctrl_nxt[`CMDC_CCR_ASM] = 1'b0;
         end
         // clearing accepted unless a fetch underrun sets the bit in the same cycle
      end
      // late fetch forces restricted mode, winning over a clear the same cycle
      if (i_fetch_underrun) begin
         core_ctrl_nxt[`CMDC_CCR_ASM] = 1'b1;
      end
   end

   // core control register; only software ever clears the restricted bit
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         core_ctrl_r <= `CMDC_CCR_RESET;
      end else begin
         core_ctrl_r <= core_ctrl_nxt;
      end
   end

   // delay compensation register and cancel-done enables
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         delay_comp_r                       <= `CMDC_TDC_RESET;
         tx_buffer_cancel_done_irq_enable_r <= `CMDC_CANCEL_IRQ_RESET;
      end else if (wr_go) begin
         if (sel(i_avs_address, `CMDC_OFF_DELAY_COMP)) begin
            delay_comp_r <= merge_be(delay_comp_r, i_avs_writedata, i_avs_byteenable)
                            & {25'h0, 7'h7f};
         end
         if (sel(i_avs_address, `CMDC_OFF_CANCEL_IRQ_EN)) begin
            tx_buffer_cancel_done_irq_enable_r <= merge_be(tx_buffer_cancel_done_irq_enable_r,
                                                  i_avs_writedata, i_avs_byteenable);
         end
      end
   end

   // pending requests; monitoring mode holds them at reset value
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tx_request_pending_reg_r <= `CMDC_TX_PENDING_RESET;
      end else if (listen_only_bit) begin
         tx_request_pending_reg_r <= `CMDC_TX_PENDING_RESET;
      end else begin
         tx_request_pending_reg_r <= (tx_request_pending_reg_r & ~i_tx_request_clr)
                                     | i_tx_request_set;
      end
   end

   // cancel-done flags: write one to clear, a new event wins over the clear
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cancel_done_r <= 32'h00000000;
      end else begin
         if (wr_go && sel(i_avs_address, `CMDC_OFF_CANCEL_DONE)) begin
            cancel_done_r <= (cancel_done_r & ~merge_be(32'h00000000, i_avs_writedata,
                             i_avs_byteenable)) | i_cancel_done;
         end else begin
            cancel_done_r <= cancel_done_r | i_cancel_done;
         end
      end
   end

   // interrupt only for completed buffers whose enable is set
   assign o_cancel_irq = |(cancel_done_r & tx_buffer_cancel_done_irq_enable_r);

   // restricted mode error/overload: hold off until the bus goes idle
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         hold_sync_r <= 1'b0;
      end else if (!restricted_op_bit || i_proto_bus_idle) begin
         hold_sync_r <= 1'b0;
      end else if (i_proto_err_event) begin
         hold_sync_r <= 1'b1;
      end
   end
   assign o_proto_hold_sync = hold_sync_r;

   // no frame starts in restricted or monitoring mode
   assign o_proto_tx_allow = ~restricted_op_bit & ~listen_only_bit;
   assign o_proto_err_inc_en = ~restricted_op_bit;

   // monitoring: required dominant bits seen internally, bus stays recessive
   assign o_proto_rx = rx_level_r &
                       ~(listen_only_bit & i_proto_tx_dom_req & ~i_proto_tx);

   // tx pin: restricted mode may still drive ack but never error/overload flags
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_can_tx <= 1'b1;
      end else if (listen_only_bit) begin
         o_can_tx <= 1'b1;
      end else if (restricted_op_bit && (hold_sync_r || i_proto_err_event)) begin
         o_can_tx <= 1'b1;
      end else if (restricted_op_bit && !i_proto_tx_dom_req) begin
         o_can_tx <= 1'b1;
      end else begin
         o_can_tx <= i_proto_tx;
      end
   end

   // transmitter delay measurement
   cmdc_delay_meas u_meas (
      .i_ref_clk  (i_ref_clk),
      .i_rst_b    (i_rst_b),
      .i_start    (i_proto_meas_start),
      .i_rx       (rx_level_r),
      .i_filt_win (delay_comp_r[`CMDC_TDC_FILT_LSB +: `CMDC_TDC_W]),
      .o_ssp_pos  (o_ssp_pos),
      .o_busy     (meas_busy),
      .o_done     ()
   );

   // read data registered in the wait cycle so it already stands at the accepting edge
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_avs_readdata <= 32'h00000000;
      end else if (i_avs_read && !ack_r) begin
         case (i_avs_address)
            `CMDC_OFF_CORE_CTRL:     o_avs_readdata <= core_ctrl_r;
            `CMDC_OFF_DELAY_COMP:    o_avs_readdata <= delay_comp_r;
            `CMDC_OFF_TX_PENDING:    o_avs_readdata <= tx_request_pending_reg_r;
            `CMDC_OFF_CANCEL_DONE:   o_avs_readdata <= cancel_done_r;
            `CMDC_OFF_CANCEL_IRQ_EN: o_avs_readdata <= tx_buffer_cancel_done_irq_enable_r;
            `CMDC_OFF_STATUS:        o_avs_readdata <= {24'h000000, meas_busy,
                                                        o_ssp_pos};
            default:                 o_avs_readdata <= `CMDC_RDATA_UNMAPPED;
         endcase
      end
   end

endmodule // cmdc_mode_ctrl
`default_nettype wire

// *** verification/cmdc_xcvr_model.sv ***
// cmdc_xcvr_model.sv: transceiver plus remote nodes, wired-and bus with loop delay
// assumes: 1 is recessive, the bus idles recessive through the termination
`timescale 1ns/1ps
`default_nettype none
module cmdc_xcvr_model (
   input  wire logic i_ref_clk,    // bench clock
   input  wire logic i_tx,         // node drive, 1 = recessive
   input  wire logic i_remote_dom, // a remote node drives dominant
   output var  logic o_rx          // delayed bus level back to the node
);
   logic [1:0] dly_r = 2'b11;
   // two cycles of loop delay so that the delay measurement sees a real offset
   always @(posedge i_ref_clk) begin
      dly_r <= {dly_r[0], i_tx & ~i_remote_dom};
   end
   assign o_rx = dly_r[1];
endmodule // cmdc_xcvr_model
`default_nettype wire

// *** verification/cmdc_mode_ctrl_assertions.sv ***
// cmdc_mode_ctrl_assertions.sv: port-level checks of the mode block
// assumes: bound into cmdc_mode_ctrl, single clock, reset low active
`timescale 1ns/1ps
`default_nettype none
module cmdc_chk (
   input wire logic        i_ref_clk,          // clock
   input wire logic        i_rst_b,            // reset
   input wire logic        i_avs_write,        // write strobe
   input wire logic        i_avs_read,         // read strobe
   input wire logic        o_avs_waitrequest,  // stall
   input wire logic        o_can_tx,           // bus drive
   input wire logic        i_proto_tx,         // engine level
   input wire logic        i_proto_tx_dom_req, // required dominant
   input wire logic        i_proto_err_event,  // error seen
   input wire logic        i_proto_bus_idle,   // idle seen
   input wire logic        i_fetch_underrun,   // handler late
   input wire logic [31:0] i_cancel_done,      // cancel pulses
   input wire logic        o_proto_rx,         // engine rx
   input wire logic        o_proto_tx_allow,   // start allowed
   input wire logic        o_proto_err_inc_en, // counters count
   input wire logic        o_proto_hold_sync,  // wait for idle
   input wire logic        o_cancel_irq        // interrupt
);
   logic cause_r;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   // an interrupt may only rise after a cancel pulse or a register write
   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) cause_r <= 1'b0;
      else cause_r <= (|i_cancel_done) | (i_avs_write & ~o_avs_waitrequest);
   end
   chk_underrun_entry: assert property (i_fetch_underrun |=> !o_proto_err_inc_en)
      else $error("underrun did not enter restricted mode");
   chk_rop_sticky: assert property (
      (!o_proto_err_inc_en && !(i_avs_write && !o_avs_waitrequest)) |=> !o_proto_err_inc_en)
      else $error("restricted mode left without a write");
   chk_rop_no_start: assert property (!o_proto_err_inc_en |-> !o_proto_tx_allow)
      else $error("frame start allowed in restricted mode");
   chk_rop_recessive: assert property (
      (!o_proto_err_inc_en && !i_proto_tx_dom_req) |=> o_can_tx)
      else $error("restricted mode drove a dominant frame bit");
   chk_err_holds: assert property (
      (!o_proto_err_inc_en && i_proto_err_event && !i_proto_bus_idle) |=> o_proto_hold_sync)
      else $error("error in restricted mode did not hold for idle");
   chk_hold_recessive: assert property (o_proto_hold_sync |=> o_can_tx)
      else $error("dominant bit while waiting for bus idle");
   chk_listen_recessive: assert property (
      (!o_proto_tx_allow && o_proto_err_inc_en) |=> o_can_tx)
      else $error("listen-only mode drove dominant");
   chk_listen_loop: assert property (
      (!o_proto_tx_allow && o_proto_err_inc_en && i_proto_tx_dom_req && !i_proto_tx) [*2]
      |-> !o_proto_rx)
      else $error("required dominant bit not looped back");
   chk_irq_cause: assert property ($rose(o_cancel_irq) |-> cause_r)
      else $error("cancel interrupt rose without a cause");
   chk_one_wait: assert property (
      (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("register access stalled past one wait state");
endmodule // cmdc_chk
bind cmdc_mode_ctrl cmdc_chk u_chk (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
   .i_avs_write(i_avs_write), .i_avs_read(i_avs_read), .o_avs_waitrequest(o_avs_waitrequest),
   .o_can_tx(o_can_tx), .i_proto_tx(i_proto_tx), .i_proto_tx_dom_req(i_proto_tx_dom_req),
   .i_proto_err_event(i_proto_err_event), .i_proto_bus_idle(i_proto_bus_idle),
   .i_fetch_underrun(i_fetch_underrun), .i_cancel_done(i_cancel_done), .o_proto_rx(o_proto_rx),
   .o_proto_tx_allow(o_proto_tx_allow), .o_proto_err_inc_en(o_proto_err_inc_en),
   .o_proto_hold_sync(o_proto_hold_sync), .o_cancel_irq(o_cancel_irq));
`default_nettype wire

// *** verification/test_can_mode_and_delay_comp.sv ***
// test_can_mode_and_delay_comp.sv: self-checking bench with a register model
// assumes: one wait state per access, bus level from cmdc_xcvr_model
`timescale 1ns/1ps
`default_nettype none
module test_can_mode_and_delay_comp;
   logic        i_ref_clk = 0, i_rst_b = 0, rd = 0, wr = 0, remote = 0;
   logic [7:0]  adr = 0;
   logic [31:0] wd = 0, rset = 0, rclr = 0, cdone = 0, rdata, seed = 32'hf4969c05;
   logic        ptx = 1, pstart = 0, pdom = 0, perr = 0, pidle = 0, pev = 0, pmeas = 0, und = 0;
   logic        wreq, ctx, prx, pallow, peren, phold, irq, pin;
   logic [6:0]  pos;
   logic [31:0] m_en = 0, m_flg = 0, m_ctl = 1, m_tdc = 0, m_pend = 0;
   int          tests_run = 0, bad_count = 0;
   cmdc_mode_ctrl dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_can_receive_pin(pin), .o_can_tx(ctx),
      .i_proto_tx(ptx), .i_proto_tx_start(pstart), .i_proto_tx_dom_req(pdom),
      .i_proto_err_inc(perr), .i_proto_bus_idle(pidle), .i_proto_err_event(pev),
      .i_proto_meas_start(pmeas), .i_fetch_underrun(und), .i_tx_request_set(rset),
      .i_tx_request_clr(rclr), .i_cancel_done(cdone), .o_proto_rx(prx), .o_proto_tx_allow(pallow),
      .o_proto_err_inc_en(peren), .o_proto_hold_sync(phold), .o_ssp_pos(pos), .o_cancel_irq(irq));
   cmdc_xcvr_model u_bus (.i_ref_clk(i_ref_clk), .i_tx(ctx), .i_remote_dom(remote), .o_rx(pin));
   // 20 mhz clock
   always #25 i_ref_clk = ~i_ref_clk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic summarize;
      $display("compares %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   // one avalon access; held until waitrequest is sampled low, data taken at that edge
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge i_ref_clk);
      adr <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      do begin
         @(posedge i_ref_clk);
         n++;
      end while (wreq !== 1'b0 && n < 20);
      q = rdata;
      rd <= 0;
      wr <= 0;
      if (n >= 20) begin
         bad_count++;
         summarize();
      end
      @(negedge i_ref_clk);
   endtask
   // write plus model update; the restricted bit only sets with both config bits already up
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      acc(1, a, d, q);
      case (a)
         8'he4: m_en = d;
         8'hd8: m_flg &= ~d;
         8'h48: m_tdc = d & 32'h7f;
         8'h18: m_ctl = {d[31:3], d[2] & (m_ctl[2] | (m_ctl[1] & m_ctl[0])), d[1:0]};
         default: ;
      endcase
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
      logic [31:0] q;
      acc(0, a, 32'h0, q);
      chk(q & msk, e & msk);
   endtask
   // one-cycle pulse on a chosen event input, then let it land
   task automatic pulse(input int k, input logic [31:0] v);
      @(posedge i_ref_clk);
      case (k)
         0: cdone <= v;
         1: rset <= v;
         2: rclr <= v;
         3: und <= v[0];
         4: pev <= v[0];
         default: pmeas <= v[0];
      endcase
      @(posedge i_ref_clk);
      {cdone, rset, rclr, und, pev, pmeas} <= '0;
      @(negedge i_ref_clk);
   endtask
   task automatic setp(input logic t, input logic dm, input logic idl);
      @(posedge i_ref_clk);
      ptx <= t;
      pdom <= dm;
      pidle <= idl;
      @(posedge i_ref_clk);
      @(negedge i_ref_clk);
   endtask
   // main sequence
   initial begin
      repeat (4) @(posedge i_ref_clk);
      i_rst_b <= 1;
      rreg(8'he4, '1, 32'h0);
      rreg(8'h18, 32'h25, m_ctl);
      rreg(8'h04, '1, 32'h0);
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         wreg(8'he4, seed);
         rreg(8'he4, '1, m_en);
      end
      wreg(8'he4, 32'h8);
      pulse(0, 32'h20);
      m_flg |= 32'h20;
      chk(irq, |(m_en & m_flg));
      pulse(0, 32'h8);
      m_flg |= 32'h8;
      chk(irq, |(m_en & m_flg));
      rreg(8'hd8, '1, m_flg);
      wreg(8'hd8, 32'hffffffff);
      chk(irq, 1'b0);
      // restricted mode request ignored until cce and init are both set, then accepted
      wreg(8'h18, 32'h5);
      rreg(8'h18, 32'h25, m_ctl);
      chk(peren, 1'b1);
      wreg(8'h18, 32'h3);
      wreg(8'h18, 32'h7);
      rreg(8'h18, 32'h25, m_ctl);
      chk(peren, 1'b0);
      chk(pallow, 1'b0);
      setp(0, 1, 0);
      chk(ctx, 1'b0);
      setp(0, 0, 0);
      chk(ctx, 1'b1);
      pulse(4, 1);
      chk(phold, 1'b1);
      setp(0, 1, 0);
      chk(ctx, 1'b1);
      setp(0, 0, 1);
      chk(phold, 1'b0);
      wreg(8'h18, 32'h0);
      rreg(8'h18, 32'h25, m_ctl);
      pulse(3, 1);
      m_ctl[2] = 1'b1;
      repeat (20) @(posedge i_ref_clk);
      rreg(8'h18, 32'h25, m_ctl);
      chk(peren, 1'b0);
      wreg(8'h18, 32'h1);
      rreg(8'h18, 32'h25, m_ctl);
      chk(peren, 1'b1);
      wreg(8'h18, 32'h23);
      pulse(1, 32'h5);
      rreg(8'hcc, '1, m_pend);
      chk(pallow, 1'b0);
      setp(0, 1, 0);
      repeat (6) @(negedge i_ref_clk);
      chk(ctx, 1'b1);
      chk(prx, 1'b0);
      setp(1, 0, 0);
      wreg(8'h18, 32'h1);
      pulse(1, 32'h5);
      m_pend |= 32'h5;
      pulse(2, 32'h1);
      m_pend &= ~32'h1;
      rreg(8'hcc, '1, m_pend);
      // early short dominant glitch, then the real edge well past the window
      wreg(8'h48, 32'h14);
      rreg(8'h48, 32'h7f, m_tdc);
      pulse(5, 1);
      @(posedge i_ref_clk);
      remote <= 1;
      repeat (3) @(posedge i_ref_clk);
      remote <= 0;
      repeat (24) @(posedge i_ref_clk);
      remote <= 1;
      repeat (40) @(posedge i_ref_clk);
      remote <= 0;
      @(negedge i_ref_clk);
      chk(pos >= 7'd30 && pos <= 7'd40, 1'b1);
      summarize();
   end
endmodule // test_can_mode_and_delay_comp
`default_nettype wire
